/* core/sfb_core.sv */
// Serial flash bus front end: transfer modes, hold, write latch, protection
`include "sfb_params.svh"
`default_nettype none
module sfb_core (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Serial pins
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io,
   output logic [3:0] o_io,
   output logic [3:0] o_io_oe,
   // Array side
   input wire logic [7:0] i_rd_data,
   input wire logic i_busy,
   output logic [20:0] o_rd_addr,
   output sfb_pkg::sfb_req_t o_req,
   // Status
   output logic o_write_enable_latch,
   output logic o_quad_enable,
   output logic [4:0] o_protect_bits,
   output logic o_protect_complement,
   output logic [1:0] o_status_lock,
   output logic o_sleep,
   output logic o_paused
);
   sfb_pkg::sfb_state_t r, n;
   logic [5:0] f;
   logic [3:0] din;
   logic sclk_rise, sclk_fall, cs_hi, cs_rise, hw_lock;
   logic [7:0] opc, rbyte;
   logic [23:0] wsh;
   sfb_pkg::sfb_plan_t plan;

   // Shift lanes into a word, lowest lane last
   function automatic logic [23:0] shift_in(input logic [23:0] v,
                                            input sfb_pkg::sfb_lane_t l, input logic [3:0] d);
      case (l)
         sfb_pkg::LANE2: shift_in = {v[21:0], d[1:0]};
         sfb_pkg::LANE4: shift_in = {v[19:0], d};
         default: shift_in = {v[22:0], d[0]};
      endcase
   endfunction : shift_in

   // Clocks needed for a bit count on a lane width
   function automatic logic [4:0] clocks(input logic [4:0] bits, input sfb_pkg::sfb_lane_t l);
      case (l)
         sfb_pkg::LANE2: clocks = bits >> 1;
         sfb_pkg::LANE4: clocks = bits >> 2;
         default: clocks = bits;
      endcase
   endfunction : clocks

   // Top bits of a byte onto the output lines; single mode uses line 1
   function automatic logic [3:0] lanes_out(input logic [7:0] b, input sfb_pkg::sfb_lane_t l);
      case (l)
         sfb_pkg::LANE2: lanes_out = {2'h0, b[7:6]};
         sfb_pkg::LANE4: lanes_out = b[7:4];
         default: lanes_out = {2'h0, b[7], 1'b0};
      endcase
   endfunction : lanes_out

   // Lines driven for a lane width
   function automatic logic [3:0] lane_mask(input sfb_pkg::sfb_lane_t l);
      case (l)
         sfb_pkg::LANE2: lane_mask = 4'h3;
         sfb_pkg::LANE4: lane_mask = 4'hF;
         default: lane_mask = 4'h2;
      endcase
   endfunction : lane_mask

   // Byte left after sending one clock's worth
   function automatic logic [7:0] shift_out(input logic [7:0] b, input sfb_pkg::sfb_lane_t l);
      shift_out = b << l;
   endfunction : shift_out

   // Protected-region test for one array address
   function automatic logic prot(input logic [20:0] a, input logic [4:0] bp, input logic cm);
      logic [2:0] sh;
      logic [21:0] size;
      logic hit;
      sh = bp[4] ? (bp[2] ? 3'h3 : {1'b0, 2'(bp[1:0] - 2'h1)}) : 3'(bp[2:0] - 3'h1);
      size = (bp[4] ? `SFB_SECTOR_BYTES : `SFB_BLOCK_BYTES) << sh;
      if (bp[2:0] == 3'h0) begin
         hit = 1'b0;
      end else if (bp[2:1] == 2'h3) begin
         hit = 1'b1;
      end else if (!bp[3]) begin
         hit = {1'b0, a} >= (`SFB_ARRAY_BYTES - size);
      end else begin
         hit = {1'b0, a} < size;
      end
      prot = hit ^ cm;
   endfunction : prot

   // Opcode to transfer shape; refused opcodes become a silent wait
   function automatic sfb_pkg::sfb_plan_t plan_of(input logic [7:0] op, input logic qe,
                                                  input logic slp);
      sfb_pkg::sfb_plan_t p;
      p = '{ok: 1'b1, use_addr: 1'b0, addr_lane: sfb_pkg::LANE1,
            data_lane: sfb_pkg::LANE1, dummy: 4'h0, nxt: sfb_pkg::NX_WAIT};
      case (op)
         `SFB_OP_STAT_WR: p.nxt = sfb_pkg::NX_WDATA;
         `SFB_OP_STAT_LO, `SFB_OP_STAT_HI: p.nxt = sfb_pkg::NX_RDATA;
         `SFB_OP_READ: {p.use_addr, p.nxt} = {1'b1, sfb_pkg::NX_RDATA};
         `SFB_OP_FAST: {p.use_addr, p.dummy, p.nxt} = {1'b1, `SFB_DUMMY_FAST, sfb_pkg::NX_RDATA};
         `SFB_OP_DUAL_OUT: begin
            {p.use_addr, p.dummy, p.nxt} = {1'b1, `SFB_DUMMY_FAST, sfb_pkg::NX_RDATA};
            p.data_lane = sfb_pkg::LANE2;
         end
         `SFB_OP_DUAL_IO: begin
            {p.use_addr, p.dummy, p.nxt} = {1'b1, `SFB_DUMMY_MODE, sfb_pkg::NX_RDATA};
            {p.addr_lane, p.data_lane} = {sfb_pkg::LANE2, sfb_pkg::LANE2};
         end
         `SFB_OP_QUAD_OUT: begin
            {p.ok, p.use_addr, p.dummy} = {qe, 1'b1, `SFB_DUMMY_FAST};
            {p.data_lane, p.nxt} = {sfb_pkg::LANE4, sfb_pkg::NX_RDATA};
         end
         `SFB_OP_QUAD_WORD: begin
            {p.ok, p.use_addr, p.dummy} = {qe, 1'b1, `SFB_DUMMY_MODE};
            {p.addr_lane, p.data_lane} = {sfb_pkg::LANE4, sfb_pkg::LANE4};
            p.nxt = sfb_pkg::NX_RDATA;
         end
         `SFB_OP_PAGE_PROG: {p.use_addr, p.nxt} = {1'b1, sfb_pkg::NX_WDATA};
         `SFB_OP_QUAD_PROG: begin
            {p.ok, p.use_addr, p.nxt} = {qe, 1'b1, sfb_pkg::NX_WDATA};
            p.data_lane = sfb_pkg::LANE4;
         end
         `SFB_OP_ERASE_4K, `SFB_OP_ERASE_32K, `SFB_OP_ERASE_64K: p.use_addr = 1'b1;
         `SFB_OP_SET_WL, `SFB_OP_CLR_WL, `SFB_OP_CHIP_A, `SFB_OP_CHIP_B: p.ok = 1'b1;
         `SFB_OP_SLEEP, `SFB_OP_WAKE: p.ok = 1'b1;
         default: p.ok = 1'b0;
      endcase
      if (slp && op != `SFB_OP_WAKE) begin
         p.ok = 1'b0;
      end
      if (!p.ok) begin
         {p.use_addr, p.dummy, p.nxt} = {1'b0, 4'h0, sfb_pkg::NX_WAIT};
      end
      plan_of = p;
   endfunction : plan_of

   // State that follows the address phase
   function automatic sfb_pkg::sfb_st_t next_of(input sfb_pkg::sfb_plan_t p);
      if (p.dummy != 4'h0) begin
         next_of = sfb_pkg::ST_DUMMY;
      end else if (p.nxt == sfb_pkg::NX_RDATA) begin
         next_of = sfb_pkg::ST_RDATA;
      end else if (p.nxt == sfb_pkg::NX_WDATA) begin
         next_of = sfb_pkg::ST_WDATA;
      end else begin
         next_of = sfb_pkg::ST_WAIT;
      end
   endfunction : next_of

   // Pin filter: a bit rises only once stages two and three are both high, and falls as soon as either is low
   assign f = (r.s2 & r.s3) | (r.filt & ~(r.s2 ^ r.s3));
   assign din = f[3:0];
   assign sclk_rise = f[5] & ~r.filt[5];
   assign sclk_fall = ~f[5] & r.filt[5];
   assign cs_hi = f[4];
   assign cs_rise = f[4] & ~r.filt[4];
   // Write-protect pin only counts while it is not a data line
   assign hw_lock = r.lock[1] | (r.lock == 2'h1 & ~f[2] & ~r.qe);
   assign opc = {r.sr[6:0], din[0]};
   assign plan = plan_of(opc, r.qe, r.sleep);
   assign wsh = shift_in({16'h0000, r.sr}, r.plan.data_lane, din);
   assign rbyte = (r.cmd == `SFB_OP_STAT_LO) ? {r.lock[0], r.bp, r.write_enable_latch, i_busy} :
                  (r.cmd == `SFB_OP_STAT_HI) ? {1'b0, r.cmp, 4'h0, r.qe, r.lock[1]} : i_rd_data;

   // Next state of the whole front end
   always_comb begin
      n = r;
      n.req.valid = 1'b0;
      n.s1 = {i_sclk, i_cs_n, i_io};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.filt = f;
      if (cs_hi) begin
         // A select rise while paused only resets the interface
         if (cs_rise && !r.paused) begin
            case (r.cmd)
               `SFB_OP_SET_WL: n.write_enable_latch = 1'b1;
               `SFB_OP_CLR_WL: n.write_enable_latch = 1'b0;
               `SFB_OP_STAT_WR: begin
                  if (r.write_enable_latch && !hw_lock && r.sw_cnt != 2'h0) begin
                     n.bp = r.sw_b0[`SFB_SR_BP_LSB +: 5];
                     n.lock[0] = r.sw_b0[`SFB_SR_LOCK0];
                     if (r.sw_cnt == 2'h2) begin
                        n.lock[1] = r.sw_b1[`SFB_SR_LOCK1];
                        n.qe = r.sw_b1[`SFB_SR_QUAD];
                        n.cmp = r.sw_b1[`SFB_SR_CMPL];
                     end
                  end
                  n.write_enable_latch = 1'b0;
               end
               `SFB_OP_PAGE_PROG, `SFB_OP_QUAD_PROG: n.write_enable_latch = 1'b0;
               `SFB_OP_ERASE_4K, `SFB_OP_ERASE_32K, `SFB_OP_ERASE_64K: begin
                  if (r.st == sfb_pkg::ST_WAIT && r.write_enable_latch && !prot(r.addr[20:0], r.bp, r.cmp)) begin
                     n.req.valid = 1'b1;
                     n.req.kind = (r.cmd == `SFB_OP_ERASE_4K) ? sfb_pkg::REQ_ERASE_4K :
                                  (r.cmd == `SFB_OP_ERASE_32K) ? sfb_pkg::REQ_ERASE_32K :
                                  sfb_pkg::REQ_ERASE_64K;
                     n.req.addr = r.addr[20:0];
                  end
                  n.write_enable_latch = 1'b0;
               end
               `SFB_OP_CHIP_A, `SFB_OP_CHIP_B: begin
                  if (r.write_enable_latch && r.bp[2:0] == 3'h0 && !r.cmp) begin
                     n.req.valid = 1'b1;
                     n.req.kind = sfb_pkg::REQ_ERASE_CHIP;
                     n.req.addr = 21'h00_0000;
                  end
                  n.write_enable_latch = 1'b0;
               end
               `SFB_OP_SLEEP: n.sleep = 1'b1;
               `SFB_OP_WAKE: n.sleep = 1'b0;
               default: n.sleep = r.sleep;
            endcase
         end
         // Deselect returns the interface to its idle shape
         {n.st, n.cmd, n.cnt, n.sr} = {sfb_pkg::ST_CMD, `SFB_OP_NONE, 5'h00, 8'h00};
         {n.out_cnt, n.io_oe, n.paused, n.sw_cnt} = {3'h0, 4'h0, 1'b0, 2'h0};
      end else begin
         // Hold is a level test so deferred entry and exit fall out naturally
         if (!r.qe) begin
            if (!r.paused && !f[3] && !f[5]) begin
               n.paused = 1'b1;
            end else if (r.paused && f[3] && !f[5]) begin
               n.paused = 1'b0;
            end
         end
         // Pause touches no internal operation, only clock edges are dropped
         if (sclk_rise && !r.paused && !n.paused) begin
            case (r.st)
               sfb_pkg::ST_CMD: begin
                  n.sr = opc;
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == 5'h07) begin
                     n.cnt = 5'h00;
                     n.plan = plan;
                     n.cmd = plan.ok ? opc : `SFB_OP_NONE;
                     n.st = plan.use_addr ? sfb_pkg::ST_ADDR : next_of(plan);
                  end
               end
               sfb_pkg::ST_ADDR: begin
                  n.addr = shift_in(r.addr, r.plan.addr_lane, din);
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == clocks(5'h18, r.plan.addr_lane) - 5'h01) begin
                     n.cnt = 5'h00;
                     n.st = next_of(r.plan);
                  end
               end
               sfb_pkg::ST_DUMMY: begin
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == {1'b0, r.plan.dummy} - 5'h01) begin
                     n.cnt = 5'h00;
                     n.st = sfb_pkg::ST_RDATA;
                  end
               end
               sfb_pkg::ST_WDATA: begin
                  n.sr = wsh[7:0];
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == clocks(5'h08, r.plan.data_lane) - 5'h01) begin
                     n.cnt = 5'h00;
                     if (r.cmd == `SFB_OP_STAT_WR) begin
                        n.sw_b0 = (r.sw_cnt == 2'h0) ? wsh[7:0] : r.sw_b0;
                        n.sw_b1 = (r.sw_cnt == 2'h1) ? wsh[7:0] : r.sw_b1;
                        n.sw_cnt = (r.sw_cnt == 2'h2) ? r.sw_cnt : r.sw_cnt + 2'h1;
                     end else begin
                        if (r.write_enable_latch && !prot(r.addr[20:0], r.bp, r.cmp)) begin
                           n.req = '{valid: 1'b1, kind: sfb_pkg::REQ_PROG,
                                     addr: r.addr[20:0], data: wsh[7:0]};
                        end
                        n.addr[7:0] = r.addr[7:0] + 8'h01;
                     end
                  end
               end
               default: n.cnt = r.cnt;
            endcase
         end else if (sclk_fall && !r.paused && !n.paused && r.st == sfb_pkg::ST_RDATA) begin
            // New bits appear on the falling edge; the first one loads a byte
            n.io_oe = lane_mask(r.plan.data_lane);
            if (r.out_cnt == 3'h0) begin
               n.io_out = lanes_out(rbyte, r.plan.data_lane);
               n.out_sr = shift_out(rbyte, r.plan.data_lane);
               n.out_cnt = 3'(clocks(5'h08, r.plan.data_lane) - 5'h01);
               if (r.plan.use_addr) begin
                  n.addr = r.addr + 24'h00_0001;
               end
            end else begin
               n.io_out = lanes_out(r.out_sr, r.plan.data_lane);
               n.out_sr = shift_out(r.out_sr, r.plan.data_lane);
               n.out_cnt = r.out_cnt - 3'h1;
            end
         end
      end
   end

   // State register; reset leaves the latch clear
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         r <= '0;
         r.st <= sfb_pkg::ST_CMD;
         r.s1 <= `SFB_PIN_IDLE;
         r.s2 <= `SFB_PIN_IDLE;
         r.s3 <= `SFB_PIN_IDLE;
         r.filt <= `SFB_PIN_IDLE;
      end else if (i_ce) begin
         r <= n;
      end
   end

   // Outputs; the enable drops at once when a pause begins
   assign o_io = r.io_out;
   assign o_io_oe = r.io_oe & {4{~r.paused}};
   assign o_rd_addr = r.addr[20:0];
   assign o_req = r.req;
   assign o_write_enable_latch = r.write_enable_latch;
   assign o_quad_enable = r.qe;
   assign o_protect_bits = r.bp;
   assign o_protect_complement = r.cmp;
   assign o_status_lock = r.lock;
   assign o_sleep = r.sleep;
   assign o_paused = r.paused;
endmodule : sfb_core
`default_nettype wire

/* inc/sfb_params.svh */
// Constants for the serial flash bus front end
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH
`define SFB_OP_NONE 8'h00
`define SFB_OP_SET_WL 8'h06
`define SFB_OP_CLR_WL 8'h04
`define SFB_OP_STAT_WR 8'h01
`define SFB_OP_STAT_LO 8'h05
`define SFB_OP_STAT_HI 8'h35
`define SFB_OP_READ 8'h03
`define SFB_OP_FAST 8'h0B
`define SFB_OP_DUAL_OUT 8'h3B
`define SFB_OP_DUAL_IO 8'hBB
`define SFB_OP_QUAD_OUT 8'h6B
`define SFB_OP_QUAD_WORD 8'hE7
`define SFB_OP_PAGE_PROG 8'h02
`define SFB_OP_QUAD_PROG 8'h32
`define SFB_OP_ERASE_4K 8'h20
`define SFB_OP_ERASE_32K 8'h52
`define SFB_OP_ERASE_64K 8'hD8
`define SFB_OP_CHIP_A 8'h60
`define SFB_OP_CHIP_B 8'hC7
`define SFB_OP_SLEEP 8'hB9
`define SFB_OP_WAKE 8'hAB
`define SFB_DUMMY_FAST 4'h8
`define SFB_DUMMY_MODE 4'h4
`define SFB_ARRAY_BYTES 22'h20_0000
`define SFB_BLOCK_BYTES 22'h01_0000
`define SFB_SECTOR_BYTES 22'h00_1000
`define SFB_SR_BP_LSB 2
`define SFB_SR_LOCK0 7
`define SFB_SR_LOCK1 0
`define SFB_SR_QUAD 1
`define SFB_SR_CMPL 6
`define SFB_PIN_IDLE 6'h10
`endif

/* inc/sfb_pkg.sv */
// Types for the serial flash bus front end
`default_nettype none
package sfb_pkg;
   typedef enum logic [5:0] {
      ST_CMD = 6'h01, ST_ADDR = 6'h02, ST_DUMMY = 6'h04,
      ST_WDATA = 6'h08, ST_RDATA = 6'h10, ST_WAIT = 6'h20
   } sfb_st_t;
   typedef enum logic [2:0] {LANE1 = 3'h1, LANE2 = 3'h2, LANE4 = 3'h4} sfb_lane_t;
   typedef enum logic [1:0] {NX_WAIT = 2'h0, NX_RDATA = 2'h1, NX_WDATA = 2'h2} sfb_next_t;
   typedef enum logic [2:0] {
      REQ_PROG = 3'h0, REQ_ERASE_4K = 3'h1, REQ_ERASE_32K = 3'h2,
      REQ_ERASE_64K = 3'h3, REQ_ERASE_CHIP = 3'h4
   } sfb_kind_t;
   typedef struct packed {
      logic valid;
      sfb_kind_t kind;
      logic [20:0] addr;
      logic [7:0] data;
   } sfb_req_t;
   typedef struct packed {
      logic ok;
      logic use_addr;
      sfb_lane_t addr_lane;
      sfb_lane_t data_lane;
      logic [3:0] dummy;
      sfb_next_t nxt;
   } sfb_plan_t;
   typedef struct packed {
      logic [5:0] s1, s2, s3, filt;
      sfb_st_t st;
      logic [7:0] cmd;
      sfb_plan_t plan;
      logic [4:0] cnt;
      logic [23:0] addr;
      logic [7:0] sr, out_sr;
      logic [2:0] out_cnt;
      logic [3:0] io_out, io_oe;
      logic paused, write_enable_latch, sleep, cmp, qe;
      logic [4:0] bp;
      logic [1:0] lock, sw_cnt;
      logic [7:0] sw_b0, sw_b1;
      sfb_req_t req;
   } sfb_state_t;
endpackage : sfb_pkg
`default_nettype wire

/* tb/sfb_core_chk.sv */
// Port assertions for the serial flash bus front end
`default_nettype none
module sfb_core_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Pins
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io,
   input wire logic [3:0] o_io_oe,
   // Status and requests
   input wire sfb_pkg::sfb_req_t o_req,
   input wire logic o_write_enable_latch,
   input wire logic o_quad_enable,
   input wire logic [4:0] o_protect_bits,
   input wire logic o_protect_complement,
   input wire logic o_sleep,
   input wire logic o_paused
);
   // One clock domain, so clocking and disable are given once
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   float_pause_a:
      assert property (o_paused && $past(o_paused) |-> o_io_oe == 4'h0)
      else $error("Data line driven during pause");
   pause_noquad_a:
      assert property ($rose(o_paused) |-> !o_quad_enable) else $error("Pause with quad on");
   pause_entry_a:
      assert property ($rose(o_paused) |-> !i_sclk && !i_io[3]) else $error("Bad pause entry");
   pause_exit_a:
      assert property ($fell(o_paused) |-> !i_sclk && (i_io[3] || i_cs_n))
      else $error("Bad pause exit");
   quad_lanes_a:
      assert property (o_io_oe[3:2] != 2'h0 |-> o_quad_enable) else $error("Quad lane unlocked");
   req_latch_a:
      assert property (o_req.valid |-> $past(o_write_enable_latch)) else $error("Request no latch");
   chip_erase_a:
      assert property (o_req.valid && o_req.kind == sfb_pkg::REQ_ERASE_CHIP |->
         o_protect_bits[2:0] == 3'h0 && !o_protect_complement) else $error("Chip erase let pass");
   top_block_a:
      assert property (o_req.valid && !o_protect_complement && o_protect_bits == 5'h01 |->
         o_req.addr < 21'h1F_0000) else $error("Request inside protected block");
   sleep_hold_a:
      assert property (o_sleep && $past(o_sleep) |-> $stable(o_write_enable_latch))
      else $error("Latch moved in sleep");
   set_latch_a:
      assert property ($rose(o_write_enable_latch) |-> i_cs_n && !o_sleep)
      else $error("Latch set at wrong time");
   // Main scenarios reached
   pause_c: cover property ($rose(o_paused));
   req_c: cover property (o_req.valid);
   sleep_c: cover property ($rose(o_sleep));
endmodule : sfb_core_chk
bind sfb_core sfb_core_chk chk (.i_clk, .i_reset, .i_sclk, .i_cs_n, .i_io, .o_io_oe, .o_req,
   .o_write_enable_latch, .o_quad_enable, .o_protect_bits, .o_protect_complement, .o_sleep,
   .o_paused);
`default_nettype wire

/* tb/sfb_host.sv */
// Host serial bus controller model driving clock, select and data lines
`default_nettype none
module sfb_host (
   // Resolved data lines
   input wire logic [3:0] i_line,
   // Host pins
   output logic o_sclk,
   output logic o_cs_n,
   output logic [3:0] o_io,
   output logic [3:0] o_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic mode3 = 1'h0;
   // Idle: select high, write-protect and hold high, clock still
   initial begin
      o_sclk = 1'h0;
      o_cs_n = 1'h1;
      o_io = 4'hC;
      o_oe = 4'hD;
   end
   // Clock idles low in mode 0 and high in mode 3
   task automatic start(input logic m3);
      mode3 = m3;
      o_sclk = m3;
      #125 o_cs_n = 1'h0;
      #62.5 o_sclk = 1'h0;
   endtask : start
   // Data changes while clock is low, read data taken at the rising edge
   task automatic shift(input logic [31:0] v, input int n, input int w, input logic rd,
         output logic [31:0] q);
      q = 32'h0;
      o_oe = rd ? ((w == 1) ? 4'hD : (w == 2) ? 4'hC : 4'h0) : ((w == 1) ? 4'hD : 4'hF);
      for (int i = n - w; i >= 0; i -= w) begin
         for (int b = 0; b < w; b++) o_io[b] = v[i + b];
         #62.5 o_sclk = 1'h1;
         q = (w == 1) ? {q[30:0], i_line[1]} : (q << w) | (i_line & ((w == 2) ? 4'h3 : 4'hF));
         #62.5 o_sclk = 1'h0;
      end
   endtask : shift
   // Select stays low whatever hold does inside a frame
   task automatic pin(input logic s, input logic h);
      o_sclk = s;
      o_io[3] = h;
      #100;
   endtask : pin
   // Hold comes back high together with select, well before the next frame
   task automatic stop();
      #62.5 o_sclk = mode3;
      #62.5 o_cs_n = 1'h1;
      o_io = 4'hC;
      o_oe = 4'hD;
      #250;
   endtask : stop
endmodule : sfb_host
`default_nettype wire

/* tb/sfb_core_test.sv */
// Self-checking bench for the serial flash bus front end
`default_nettype none
module sfb_core_test;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [7:0] op; logic write_enable_latch; logic slp; int reqs;} sfbt_row_t;
   logic i_clk = 1'h0;
   logic i_reset = 1'h1;
   logic i_ce = 1'h1;
   logic tog = 1'h0;
   logic busy = 1'h0;
   logic sclk, cs_n, write_enable_latch, qe, cmp, slp, paused;
   logic [3:0] h_io, h_oe, line, o_io, o_io_oe;
   logic [4:0] bp;
   logic [1:0] lock;
   logic [20:0] rd_addr;
   logic [7:0] rd_data;
   logic [31:0] q;
   sfb_pkg::sfb_req_t req, last_req;
   int errors = 0, tests_run = 0, req_cnt = 0, cycles = 0;
   sfbt_row_t rows [7] = '{'{8'h06, 1'h1, 1'h0, 0}, '{8'h04, 1'h0, 1'h0, 0},
      '{8'h06, 1'h1, 1'h0, 0}, '{8'h60, 1'h0, 1'h0, 1}, '{8'hB9, 1'h0, 1'h1, 1},
      '{8'h06, 1'h0, 1'h1, 1}, '{8'hAB, 1'h0, 1'h0, 1}};
   always #5 i_clk = ~i_clk;
   // Released lines toggle so a stale value never reads as good data
   always @(posedge i_clk) tog <= ~tog;
   assign line = (o_io_oe & o_io) | (~o_io_oe & h_oe & h_io) | (~o_io_oe & ~h_oe & {4{tog}});
   assign rd_data = rd_addr[7:0] ^ 8'h5A;
   // Count requests and the run length; a hang ends the run as a failure
   always @(posedge i_clk) begin
      cycles++;
      if (req.valid === 1'h1) begin
         req_cnt++;
         last_req <= req;
      end
      if (cycles > 50000) begin
         errors++;
         give_verdict();
      end
   end
   sfb_host host (.i_line(line), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .o_oe(h_oe));
   sfb_core uut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_io(line), .o_io(o_io), .o_io_oe(o_io_oe), .i_rd_data(rd_data), .i_busy(busy),
      .o_rd_addr(rd_addr), .o_req(req), .o_write_enable_latch(write_enable_latch), .o_quad_enable(qe),
      .o_protect_bits(bp), .o_protect_complement(cmp), .o_status_lock(lock), .o_sleep(slp),
      .o_paused(paused));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Write-only frame: opcode, optional address and data
   task automatic frame(input logic [7:0] op, input logic [31:0] a, input int an,
         input logic [31:0] d, input int dn, input int w);
      logic [31:0] t;
      host.start(1'h0);
      host.shift(op, 8, 1, 1'h0, t);
      if (an > 0) host.shift(a, an, 1, 1'h0, t);
      if (dn > 0) host.shift(d, dn, w, 1'h0, t);
      host.stop();
   endtask : frame
   // Read frame returning two bytes
   task automatic rd(input logic m3, input logic [7:0] op, input logic [23:0] a, input int dum,
         input int w, input logic [15:0] exp);
      logic [31:0] t;
      host.start(m3);
      host.shift(op, 8, 1, 1'h0, t);
      host.shift(a, 24, 1, 1'h0, t);
      if (dum > 0) host.shift(32'h0, dum, 1, 1'h0, t);
      host.shift(32'h0, 16, w, 1'h1, t);
      host.stop();
      chk("read data", exp, t);
   endtask : rd
   // Latch set, then a program or erase, then the request count
   task automatic prog(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
         input int dn, input int w, input int cnt);
      frame(8'h06, 32'h0, 0, 32'h0, 0, 1);
      frame(op, a, 24, d, dn, w);
      chk("request count", cnt, req_cnt);
   endtask : prog
   initial begin
      repeat (3) @(posedge i_clk);
      i_reset <= 1'h0;
      repeat (6) @(posedge i_clk);
      chk("reset status", 32'h0, {write_enable_latch, qe, bp, cmp, lock, slp, paused, req.valid});
      // Single-byte commands and their effect on latch, sleep and requests
      foreach (rows[i]) begin
         frame(rows[i].op, 32'h0, 0, 32'h0, 0, 1);
         chk("latch", rows[i].write_enable_latch, write_enable_latch);
         chk("sleep", rows[i].slp, slp);
         chk("requests", rows[i].reqs, req_cnt);
      end
      chk("chip erase kind", sfb_pkg::REQ_ERASE_CHIP, last_req.kind);
      frame(8'h02, 32'h100, 24, 32'hA5, 8, 1);
      chk("program without latch", 1, req_cnt);
      frame(8'h6B, 32'h20, 24, 32'h0, 16, 1);
      rd(1'h0, 8'h03, 24'h00_0010, 0, 1, 16'h4A4B);
      rd(1'h1, 8'h03, 24'h00_0012, 0, 1, 16'h4849);
      // Hold entry and exit deferred by a high clock, then select rise in pause
      host.start(1'h0);
      host.shift(8'h03, 8, 1, 1'h0, q);
      host.shift(32'h10, 24, 1, 1'h0, q);
      host.shift(32'h0, 8, 1, 1'h1, q);
      chk("byte before pause", 32'h4A, q);
      host.pin(1'h1, 1'h0);
      chk("pause held off", 1'h0, paused);
      host.pin(1'h0, 1'h0);
      chk("pause", 1'h1, paused);
      chk("lines floated", 4'h0, o_io_oe);
      host.pin(1'h1, 1'h1);
      chk("pause kept", 1'h1, paused);
      host.pin(1'h0, 1'h1);
      chk("pause left", 1'h0, paused);
      host.pin(1'h0, 1'h0);
      host.stop();
      chk("pause reset", 1'h0, paused);
      host.start(1'h0);
      host.shift(8'h06, 8, 1, 1'h0, q);
      host.pin(1'h0, 1'h0);
      host.stop();
      chk("abandoned command", 1'h0, write_enable_latch);
      // Protect the top block and turn quad on
      frame(8'h06, 32'h0, 0, 32'h0, 0, 1);
      frame(8'h01, 32'h0, 0, 32'h0402, 16, 1);
      chk("protect bits", 5'h01, bp);
      chk("quad enable", 1'h1, qe);
      chk("latch after status write", 1'h0, write_enable_latch);
      // Status reads repeat their byte; busy shows in bit 0 without blocking
      host.start(1'h0);
      host.shift(8'h35, 8, 1, 1'h0, q);
      host.shift(32'h0, 16, 1, 1'h1, q);
      host.stop();
      chk("status high read", 32'h0202, q);
      busy <= 1'h1;
      host.start(1'h0);
      host.shift(8'h05, 8, 1, 1'h0, q);
      host.shift(32'h0, 16, 1, 1'h1, q);
      host.stop();
      busy <= 1'h0;
      chk("status low read", 32'h0505, q);
      host.start(1'h0);
      host.pin(1'h0, 1'h0);
      chk("hold ignored", 1'h0, paused);
      host.stop();
      prog(8'h02, 24'h1F_0000, 8'hA5, 8, 1, 1);
      prog(8'h02, 24'h1E_FFFF, 8'h5C, 8, 1, 2);
      chk("program request", {sfb_pkg::REQ_PROG, 21'h1E_FFFF, 8'h5C}, last_req[31:0]);
      prog(8'h32, 24'h00_0200, 8'hC3, 8, 4, 3);
      chk("quad program data", 8'hC3, last_req.data);
      prog(8'h20, 24'h1F_1000, 8'h00, 0, 1, 3);
      prog(8'h20, 24'h00_1000, 8'h00, 0, 1, 4);
      chk("erase request", {sfb_pkg::REQ_ERASE_4K, 21'h00_1000}, last_req[31:8]);
      rd(1'h0, 8'h6B, 24'h00_0020, 8, 4, 16'h7A7B);
      rd(1'h1, 8'h3B, 24'h00_0030, 8, 2, 16'h6A6B);
      give_verdict();
   end
endmodule : sfb_core_test
`default_nettype wire
